// *** adcc_pkg.sv ***
// Function
// - first result after 5129 cycles, plus 40 powering
// - clear conversion-active flag at first result
// - later results every 256 cycles
// - 11-bit result split high[7:0], low[7:5]
// - interrupt request on every completed conversion
// - clearing continuous-select stops new conversions
// - no interrupt request while converter disabled
// - disabling keeps pending interrupt status
// - calibration: three bytes per reference, nine total
package adcc_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int RES_W = 11;
  localparam int CNT_W = 13;
  localparam int FIRST_CYC = 5129;
  localparam int PWRUP_CYC = 40;
  localparam int NEXT_CYC = 256;
  localparam int CAL_REFS = 3;
  localparam int CAL_PER_REF = 3;
  localparam int CAL_BYTES = CAL_REFS * CAL_PER_REF;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_RES_HI = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_RES_LO = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_STAT = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_MASK = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_CAL = 4'h7;
  localparam int CTRL_EN = 7;
  localparam int CTRL_ACTIVE = 6;
  localparam int CTRL_CONTINUOUS_SELECT = 5;
  localparam int CTRL_POWERED = 1;
  localparam int CTRL_BUSY = 0;
  localparam int STAT_DONE = 0;
  localparam int STAT_FIRST = 1;
  localparam int LO_SHIFT = 5;
  localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
  localparam logic [1:0] STAT_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } adcc_bus_req_t;
  typedef enum logic [1:0] {S_IDLE, S_PWRUP, S_FIRST, S_NEXT} adcc_state_t;
endpackage

// *** adcc_top.sv ***
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module adcc_top #(
  parameter int FIRST_CYCLES = 5129,
  // calibration bytes, arbitrary neutral values: per reference offset, gain hi, gain lo
  parameter logic [71:0] CAL_DATA = 72'h00_80_00_00_80_00_00_80_00
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire adcc_pkg::adcc_bus_req_t bus,
  input wire logic [adcc_pkg::RES_W-1:0] sample_in,
  output logic [adcc_pkg::DATA_W-1:0] rd_data,
  output logic irq,
  output logic irq_req,
  output logic conv_power_on
);
  import adcc_pkg::*;

  logic rst_meta_ff;
  logic rst_sync_ff;

  // reset released through two flops, asserted at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  logic rst_i_n;
  assign rst_i_n = rst_sync_ff;

  adcc_state_t st_ff, nxt_st;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic en_ff, nxt_en;
  logic active_ff, nxt_active;
  logic continuous_select_ff, nxt_continuous_select;
  logic powered_ff, nxt_powered;
  logic done;
  logic done_first;

  logic wr_ctrl;
  assign wr_ctrl = bus.wr && (bus.addr == OFS_CTRL);

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_en = en_ff;
    nxt_continuous_select = continuous_select_ff;
    nxt_active = active_ff;
    nxt_powered = powered_ff;
    done = 1'b0;
    done_first = 1'b0;
    if (wr_ctrl) begin
      nxt_en = bus.wdata[CTRL_EN];
      nxt_continuous_select = bus.wdata[CTRL_CONTINUOUS_SELECT];
      // launch only from idle; a running sequence ignores the written flag, which stays high until the first result
      if (st_ff == S_IDLE) begin
        nxt_active = bus.wdata[CTRL_ACTIVE];
      end
    end
    case (st_ff)
      S_IDLE: begin
        if (en_ff && active_ff) begin
          if (powered_ff) begin
            nxt_st = S_FIRST;
            nxt_cnt = CNT_W'(FIRST_CYCLES - 1);
          end else begin
            nxt_st = S_PWRUP;
            nxt_cnt = CNT_W'(PWRUP_CYC - 1);
          end
        end
      end
      S_PWRUP: begin
        if (cnt_ff == '0) begin
          nxt_powered = 1'b1;
          nxt_st = S_FIRST;
          nxt_cnt = CNT_W'(FIRST_CYCLES - 1);
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      S_FIRST: begin
        if (cnt_ff == '0) begin
          done = 1'b1;
          done_first = 1'b1;
          nxt_active = 1'b0;
          // continuous-select is sampled here: cleared means stop
          nxt_st = continuous_select_ff ? S_NEXT : S_IDLE;
          nxt_cnt = CNT_W'(NEXT_CYC - 1);
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      S_NEXT: begin
        if (cnt_ff == '0) begin
          done = 1'b1;
          nxt_st = continuous_select_ff ? S_NEXT : S_IDLE;
          nxt_cnt = CNT_W'(NEXT_CYC - 1);
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      default: begin
        nxt_st = S_IDLE;
      end
    endcase
    // disable aborts without a result, so no request can follow
    if (!en_ff) begin
      nxt_st = S_IDLE;
      nxt_powered = 1'b0;
      done = 1'b0;
      done_first = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      st_ff <= S_IDLE;
      cnt_ff <= '0;
      en_ff <= CTRL_RST[CTRL_EN];
      continuous_select_ff <= CTRL_RST[CTRL_CONTINUOUS_SELECT];
      active_ff <= CTRL_RST[CTRL_ACTIVE];
      powered_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      en_ff <= nxt_en;
      continuous_select_ff <= nxt_continuous_select;
      active_ff <= nxt_active;
      powered_ff <= nxt_powered;
    end
  end

  logic [DATA_W-1:0] res_hi_ff, nxt_res_hi;
  logic [DATA_W-1:0] res_lo_ff, nxt_res_lo;
  logic [1:0] stat_ff, nxt_stat;
  logic [1:0] mask_ff, nxt_mask;
  logic irq_ff, nxt_irq;
  logic irq_req_ff, nxt_irq_req;
  logic pwr_ff, nxt_pwr;
  logic [DATA_W-1:0] rd_data_ff, nxt_rd_data;
  logic [CAL_BYTES*DATA_W-1:0] cal_mem;
  logic [3:0] cal_idx;

  // byte 0 of each reference is offset, then two gain bytes
  assign cal_mem = CAL_DATA;
  // nine bytes from the cal base up to the top of the 4-bit map
  assign cal_idx = bus.addr - OFS_CAL;

  always_comb begin
    nxt_res_hi = res_hi_ff;
    nxt_res_lo = res_lo_ff;
    nxt_stat = stat_ff;
    nxt_mask = mask_ff;
    nxt_rd_data = '0;
    if (done) begin
      nxt_res_hi = sample_in[RES_W-1:RES_W-DATA_W];
      nxt_res_lo = {sample_in[RES_W-DATA_W-1:0], 5'h00};
    end
    if (bus.wr && bus.addr == OFS_STAT) begin
      nxt_stat = stat_ff & ~bus.wdata[1:0];
    end
    if (bus.wr && bus.addr == OFS_MASK) begin
      nxt_mask = bus.wdata[1:0];
    end
    // set after clear so a same-cycle event survives; disable never clears
    if (done) begin
      nxt_stat[STAT_DONE] = 1'b1;
    end
    if (done_first) begin
      nxt_stat[STAT_FIRST] = 1'b1;
    end
    nxt_irq = |(nxt_stat & nxt_mask);
    nxt_irq_req = done;
    nxt_pwr = nxt_en;
    if (bus.rd) begin
      case (bus.addr)
        OFS_CTRL: begin
          nxt_rd_data[CTRL_EN] = en_ff;
          nxt_rd_data[CTRL_ACTIVE] = active_ff;
          nxt_rd_data[CTRL_CONTINUOUS_SELECT] = continuous_select_ff;
          nxt_rd_data[CTRL_POWERED] = powered_ff;
          nxt_rd_data[CTRL_BUSY] = (st_ff != S_IDLE);
        end
        OFS_RES_HI: begin
          nxt_rd_data = res_hi_ff;
        end
        OFS_RES_LO: begin
          nxt_rd_data = res_lo_ff;
        end
        OFS_STAT: begin
          nxt_rd_data = {6'h00, stat_ff};
        end
        OFS_MASK: begin
          nxt_rd_data = {6'h00, mask_ff};
        end
        default: begin
          if (bus.addr >= OFS_CAL) begin
            nxt_rd_data = cal_mem[cal_idx*DATA_W +: DATA_W];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      res_hi_ff <= '0;
      res_lo_ff <= '0;
      stat_ff <= STAT_RST;
      mask_ff <= MASK_RST;
      irq_ff <= 1'b0;
      irq_req_ff <= 1'b0;
      pwr_ff <= 1'b0;
      rd_data_ff <= '0;
    end else begin
      res_hi_ff <= nxt_res_hi;
      res_lo_ff <= nxt_res_lo;
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      irq_ff <= nxt_irq;
      irq_req_ff <= nxt_irq_req;
      pwr_ff <= nxt_pwr;
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_data = rd_data_ff;
  assign irq = irq_ff;
  assign irq_req = irq_req_ff;
  assign conv_power_on = pwr_ff;

  // dwell counter for checking the conversion intervals
  logic [CNT_W-1:0] dwell_ff;
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      dwell_ff <= '0;
    end else begin
      dwell_ff <= (nxt_st != st_ff || done) ? '0 : dwell_ff + 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_i_n);

  AST_FIRST_TIME: assert property (
    (done_first) |-> (dwell_ff == CNT_W'(FIRST_CYCLES - 1)))
    else $error("first conversion length wrong");
  AST_PWRUP_TIME: assert property (
    (st_ff == S_PWRUP && nxt_st == S_FIRST) |-> (dwell_ff == CNT_W'(PWRUP_CYC - 1)))
    else $error("power-up length wrong");
  AST_ACTIVE_CLR: assert property (
    done_first |=> !active_ff)
    else $error("active flag not cleared");
  AST_ACTIVE_LOW: assert property (
    (st_ff == S_NEXT) |-> !active_ff)
    else $error("active flag set during sequence");
  AST_NEXT_TIME: assert property (
    (done && st_ff == S_NEXT) |-> (dwell_ff == CNT_W'(NEXT_CYC - 1)))
    else $error("conversion interval wrong");
  AST_RES_PACK: assert property (
    done |=> (res_hi_ff == $past(sample_in[10:3])) && (res_lo_ff[7:5] == $past(sample_in[2:0]))
      && (res_lo_ff[4:0] == 5'h00))
    else $error("result packing wrong");
  AST_IRQ_REQ: assert property (
    done |=> irq_req_ff && stat_ff[STAT_DONE])
    else $error("missing conversion interrupt");
  AST_STOP: assert property (
    (done && !continuous_select_ff) |=> (st_ff == S_IDLE) ##1 (st_ff == S_IDLE || active_ff))
    else $error("conversion continued after stop");
  AST_NO_IRQ_DIS: assert property (
    (!en_ff && !$past(en_ff)) |-> !irq_req_ff)
    else $error("interrupt while disabled");
  AST_KEEP_PEND: assert property (
    $fell(en_ff) |-> ((stat_ff & $past(stat_ff)) == $past(stat_ff)))
    else $error("pending interrupt lost on disable");

  // sequencing and status guards
  AST_DIS_IDLE: assert property (
    !en_ff |=> (st_ff == S_IDLE))
    else $error("sequence kept running while disabled");
  AST_PWR_CLR: assert property (
    !en_ff |=> !powered_ff)
    else $error("converter still marked powered");
  AST_LAUNCH: assert property (
    (st_ff == S_IDLE && en_ff && active_ff) |=> (st_ff != S_IDLE))
    else $error("launch not taken");
  AST_CONTINUOUS_SELECT_NEXT: assert property (
    (done && continuous_select_ff) |=> (st_ff == S_NEXT) && (cnt_ff == CNT_W'(NEXT_CYC - 1)))
    else $error("continuous interval not reloaded");
  AST_RES_HOLD: assert property (
    !done |=> $stable(res_hi_ff) && $stable(res_lo_ff))
    else $error("result changed without a conversion");
  AST_REQ_PULSE: assert property (
    irq_req_ff |=> !irq_req_ff)
    else $error("interrupt request longer than one cycle");
  AST_SET_WINS: assert property (
    (done && bus.wr && (bus.addr == OFS_STAT)) |=> stat_ff[STAT_DONE])
    else $error("status clear beat a conversion event");
  AST_STAT_KEEP: assert property (
    (!done && !(bus.wr && (bus.addr == OFS_STAT))) |=> $stable(stat_ff))
    else $error("status changed without event or clear");
endmodule

// *** adcc_conv_model.sv ***
`timescale 1ns/1ps
module adcc_conv_model (
  input wire logic clk,
  input wire logic power_on,
  input wire logic [10:0] level,
  output logic [10:0] sample
);
  initial sample = 11'h000;
  // an unpowered front end gives no stable value, so it toggles every cycle
  always @(posedge clk) begin
    if (power_on) begin
      sample <= level;
    end else begin
      sample <= ~sample;
    end
  end
endmodule

// *** adc_continuous_conversion_ctrl_bench.sv ***
`timescale 1ns/1ps
module adc_continuous_conversion_ctrl_bench;
  import adcc_pkg::*;
  localparam int FC = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  adcc_bus_req_t bus = '0;
  logic [RES_W-1:0] level = 11'h000;
  logic [RES_W-1:0] sample;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] v;
  logic irq;
  logic irq_req;
  logic pwr;
  int n_mismatch = 0;
  int tests_run = 0;
  int seed = 56226;
  int l1;
  int l2;
  int n;
  always #25 clk = ~clk;
  adcc_top #(.FIRST_CYCLES(FC)) u_adcc_top (.clk(clk), .rst_n(rst_n), .bus(bus),
    .sample_in(sample), .rd_data(rd_data), .irq(irq), .irq_req(irq_req), .conv_power_on(pwr));
  adcc_conv_model u_adcc_conv_model (.clk(clk), .power_on(pwr), .level(level), .sample(sample));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d of %0d compares", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    d = rd_data;
  endtask
  task automatic wait_irq(input int lim, output int cyc);
    cyc = 0;
    do begin
      @(posedge clk);
      #1;
      cyc++;
    end while (irq_req !== 1'b1 && cyc < lim);
    if (irq_req !== 1'b1) begin
      n_mismatch++;
      conclude();
    end
  endtask
  task automatic quiet(input int c);
    repeat (c) begin
      @(posedge clk);
      #1;
      check(irq_req, 1'b0);
    end
  endtask
  task automatic check_result();
    rd(OFS_RES_HI, v);
    check(v, level[10:3]);
    rd(OFS_RES_LO, v);
    check(v, {level[2:0], 5'h00});
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(OFS_CTRL, v);
    check(v, CTRL_RST);
    rd(OFS_STAT, v);
    check(v, 8'h00);
    wr(OFS_MASK, 8'h01);
    // single conversions: first one pays the power-up
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      level <= 11'($random(seed));
      wr(OFS_CTRL, 8'hC0);
      wait_irq(2000, n);
      if (i == 0) l1 = n;
      else l2 = n;
      check(irq, 1'b1);
      check_result();
      rd(OFS_CTRL, v);
      check(v[CTRL_ACTIVE], 1'b0);
      rd(OFS_STAT, v);
      // every launch begins with a first conversion
      check(v, 8'h03);
      wr(OFS_STAT, 8'h03);
      #1;
      check(irq, 1'b0);
    end
    check(16'(l1 - l2), 16'd40);
    check(l2 > FC, 1'b1);
    // continuous run, results every 256 cycles
    level <= 11'h400;
    wr(OFS_CTRL, 8'hE0);
    wait_irq(2000, n);
    check(n, l2);
    wait_irq(300, n);
    check(n, 256);
    @(posedge clk);
    level <= 11'($random(seed));
    wait_irq(300, n);
    check(n + 1, 256);
    check_result();
    rd(OFS_CTRL, v);
    check(v[CTRL_ACTIVE], 1'b0);
    // stop: one interval already running finishes, then silence
    wr(OFS_CTRL, 8'h80);
    wait_irq(300, n);
    quiet(600);
    rd(OFS_CTRL, v);
    check(v, 8'h82);
    // disable during a conversion with status still pending
    wr(OFS_CTRL, 8'hC0);
    repeat (10) @(posedge clk);
    rd(OFS_CTRL, v);
    check(v, 8'hC3);
    wr(OFS_CTRL, 8'h00);
    quiet(400);
    check(irq, 1'b1);
    check(pwr, 1'b0);
    rd(OFS_STAT, v);
    check(v[STAT_DONE], 1'b1);
    for (int k = 0; k < CAL_BYTES; k++) begin
      rd(OFS_CAL + 4'(k), v);
      check(v, 8'(72'h00_80_00_00_80_00_00_80_00 >> (8 * k)));
    end
    rd(4'h5, v);
    check(v, 8'h00);
    conclude();
  end
endmodule
